// ===== include/asr_pkg.sv
// Constants and types shared by both ends of the serial result readout link.
// Assumes a 200 MHz system clock on each end and a link joined by asr_link_if.
// Operation
// - Result readable after, during, or split across conversions.
// - First rising bit clock edge starts shifting.
// - Twelve-bit two's complement word, MSB first.
// - Host samples bits on falling clock edge; asr_host samples at the end of each low phase instead.
// - Rising-edge host adds one extra clock period.
// - Host parks clock low or deselects before busy.
// - Load blocked keeps old contents, drops result.
// - Shift register loads only at conversion end.
// - Host keeps bit clock static before next conversion.
// - In-conversion reads use fast clock, finish early.
// - Deselect disables outputs and blocks bit clock.
// - Deselect disables outputs at any moment.
// - Bit clock driven only in internal mode.
// - Falling trigger starts conversion whatever the select.
// - Deselected internal transfer runs, result lost.
// - Host parks clock five microseconds before busy.
// - Trigger ignored while conversion in progress.
package asr_pkg;

	// ****************************************************************
	// Word format and timing.
	// ****************************************************************
	localparam int          WORD_W        = 12;
	localparam int          CNT_W         = 4;
	localparam int          CLK_PERIOD_NS = 5;
	localparam int          SAMPLE_TRIGGER_N_TIME_NS  = 12000;
	localparam int          SAMPLE_TRIGGER_N_CYCLES   = SAMPLE_TRIGGER_N_TIME_NS / CLK_PERIOD_NS;
	localparam int          PARK_TIME_NS  = 5000;
	localparam int          PARK_CYCLES   = PARK_TIME_NS / CLK_PERIOD_NS;
	localparam int          INT_HALF_NS   = 355;
	localparam int          INT_HALF_CYC  = INT_HALF_NS / CLK_PERIOD_NS;
	localparam int          HOST_HALF_CYC = 8;
	localparam int          SAMPLE_TRIGGER_N_CNT_W    = 16;
	localparam int          HALF_CNT_W    = 8;
	localparam logic [11:0] RESULT_RST    = 12'h000;

	typedef logic [WORD_W-1:0] asr_word_t;

	typedef enum logic [1:0] {
		ASR_IDLE  = 2'b00,
		ASR_SAMPLE_TRIGGER_N  = 2'b01,
		ASR_LOAD  = 2'b10
	} asr_state_e;

	typedef enum logic [1:0] {
		ASRH_IDLE = 2'b00,
		ASRH_HIGH = 2'b01,
		ASRH_LOW  = 2'b10,
		ASRH_DONE = 2'b11
	} asr_host_e;

endpackage : asr_pkg

// ===== include/asr_link_if.sv
// Link between the converter end and the host end.
// Assumes the bench resolves the bit clock and data wires from the enables.
interface asr_link_if;
	logic sample_trigger_n;
	logic clock_source_select;
	logic cs_n;
	logic busy;
	logic sbc_host;
	logic sbc_dev;
	logic sbc_dev_oe_n;
	logic data_dev;
	logic data_oe_n;
	logic serial_bit_clock;
	logic data_line;

	modport dev (
		input  sample_trigger_n, clock_source_select, cs_n, sbc_host,
		output busy, sbc_dev, sbc_dev_oe_n, data_dev, data_oe_n
	);
	modport host (
		input  busy, serial_bit_clock, data_line,
		output sample_trigger_n, clock_source_select, cs_n, sbc_host
	);
endinterface : asr_link_if

// ===== rtl/asr_buf2.sv
// Two-entry valid/ready buffer for result words.
// Assumes source and sink on the same clock.
module asr_buf2
	import asr_pkg::*;
(
	input  wire logic           clk_i,
	input  wire logic           rst_b_i,
	input  wire logic           in_valid_i,
	output logic                in_ready_o,
	input  wire asr_pkg::asr_word_t in_data_i,
	output logic                out_valid_o,
	input  wire logic           out_ready_i,
	output asr_pkg::asr_word_t  out_data_o
);
	import asr_pkg::*;

	asr_word_t  mem_ff [2];
	asr_word_t  nxt_mem [2];
	logic       wr_ff, rd_ff, nxt_wr, nxt_rd;
	logic [1:0] cnt_ff, nxt_cnt;
	logic       push, pop;

	assign in_ready_o  = (cnt_ff != 2'h2);
	assign out_valid_o = (cnt_ff != 2'h0);
	assign out_data_o  = mem_ff[rd_ff];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always_comb begin
		nxt_mem = mem_ff;
		nxt_wr  = wr_ff;
		nxt_rd  = rd_ff;
		nxt_cnt = cnt_ff;
		if (push) begin
			nxt_mem[wr_ff] = in_data_i;
			nxt_wr         = ~wr_ff;
		end
		if (pop) begin
			nxt_rd = ~rd_ff;
		end
		nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			mem_ff[0] <= RESULT_RST;
			mem_ff[1] <= RESULT_RST;
			wr_ff     <= 1'b0;
			rd_ff     <= 1'b0;
			cnt_ff    <= 2'h0;
		end else begin
			mem_ff <= nxt_mem;
			wr_ff  <= nxt_wr;
			rd_ff  <= nxt_rd;
			cnt_ff <= nxt_cnt;
		end
	end
endmodule : asr_buf2

// ===== rtl/asr_dev.sv
// Converter end: conversion timing, output shift register and serial port.
// Assumes link pins come from outside the clock domain and are synchronised here.
module asr_dev
	import asr_pkg::*;
(
	input  wire logic           clk_i,
	input  wire logic           rst_b_i,
	asr_link_if.dev             link,
	input  wire asr_pkg::asr_word_t result_i,
	output logic                sample_trigger_n_active_o
);
	import asr_pkg::*;

	// ****************************************************************
	// Input synchronisers.
	// ****************************************************************
	logic [3:0] s1_ff, s2_ff;
	logic       trig_n, ext_mode, cs_n, sbc;
	logic       trig_d_ff, sbc_d_ff;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			s1_ff     <= 4'hF;
			s2_ff     <= 4'hF;
			trig_d_ff <= 1'b1;
			sbc_d_ff  <= 1'b0;
		end else begin
			s1_ff     <= {link.sample_trigger_n, link.clock_source_select, link.cs_n, link.sbc_host};
			s2_ff     <= s1_ff;
			trig_d_ff <= trig_n;
			sbc_d_ff  <= sbc;
		end
	end

	assign trig_n   = s2_ff[3];
	assign ext_mode = s2_ff[2];
	assign cs_n     = s2_ff[1];
	assign sbc      = s2_ff[0] & ~s2_ff[1];

	// ****************************************************************
	// Conversion sequencer and shift register.
	// ****************************************************************
	asr_state_e             st_ff, nxt_st;
	logic [SAMPLE_TRIGGER_N_CNT_W-1:0]  cnt_ff, nxt_cnt;
	asr_word_t              sr_ff, nxt_sr;
	logic [CNT_W-1:0]       bit_ff, nxt_bit;
	logic                   busy_ff, nxt_busy;
	logic                   shifting_ff, nxt_shifting;
	logic                   iclk_ff, nxt_iclk;
	logic [HALF_CNT_W-1:0]  half_ff, nxt_half;
	logic                   trig_fall, sbc_rise, sbc_fall;

	assign trig_fall = trig_d_ff & ~trig_n;
	assign sbc_rise  = sbc & ~sbc_d_ff;
	assign sbc_fall  = ~sbc & sbc_d_ff;

	always_comb begin
		nxt_st       = st_ff;
		nxt_cnt      = cnt_ff;
		nxt_sr       = sr_ff;
		nxt_bit      = bit_ff;
		nxt_busy     = busy_ff;
		nxt_shifting = shifting_ff;
		nxt_iclk     = iclk_ff;
		nxt_half     = half_ff;
		case (st_ff)
			ASR_IDLE: begin
				if (trig_fall) begin
					nxt_st   = ASR_SAMPLE_TRIGGER_N;
					nxt_cnt  = SAMPLE_TRIGGER_N_CNT_W'(SAMPLE_TRIGGER_N_CYCLES - 1);
					nxt_busy = 1'b0;
					if (!ext_mode) begin
						nxt_shifting = 1'b1;
						nxt_bit      = CNT_W'(WORD_W);
						nxt_half     = HALF_CNT_W'(INT_HALF_CYC - 1);
						nxt_iclk     = 1'b0;
					end
				end
			end
			ASR_SAMPLE_TRIGGER_N: begin
				nxt_cnt = cnt_ff - SAMPLE_TRIGGER_N_CNT_W'(1);
				if (cnt_ff == '0) begin
					nxt_st = ASR_LOAD;
				end
			end
			ASR_LOAD: begin
				if (!ext_mode || !sbc || cs_n) begin
					nxt_sr = result_i;
				end
				nxt_bit      = '0;
				nxt_shifting = 1'b0;
				nxt_iclk     = 1'b0;
				nxt_busy     = 1'b1;
				nxt_st       = ASR_IDLE;
			end
			default: begin
				nxt_st = ASR_IDLE;
			end
		endcase
		if (ext_mode) begin
			if (sbc_rise && st_ff != ASR_LOAD) begin
				if (shifting_ff) begin
					nxt_sr = {sr_ff[WORD_W-2:0], 1'b0};
				end
				nxt_shifting = 1'b1;
			end
		end else if (shifting_ff && st_ff == ASR_SAMPLE_TRIGGER_N) begin
			if (half_ff == '0) begin
				nxt_half = HALF_CNT_W'(INT_HALF_CYC - 1);
				nxt_iclk = ~iclk_ff;
				if (iclk_ff) begin
					nxt_sr  = {sr_ff[WORD_W-2:0], 1'b0};
					nxt_bit = bit_ff - CNT_W'(1);
					if (bit_ff == CNT_W'(1)) begin
						nxt_shifting = 1'b0;
					end
				end
			end else begin
				nxt_half = half_ff - HALF_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			st_ff       <= ASR_IDLE;
			cnt_ff      <= '0;
			sr_ff       <= RESULT_RST;
			bit_ff      <= '0;
			busy_ff     <= 1'b1;
			shifting_ff <= 1'b0;
			iclk_ff     <= 1'b0;
			half_ff     <= '0;
		end else begin
			st_ff       <= nxt_st;
			cnt_ff      <= nxt_cnt;
			sr_ff       <= nxt_sr;
			bit_ff      <= nxt_bit;
			busy_ff     <= nxt_busy;
			shifting_ff <= nxt_shifting;
			iclk_ff     <= nxt_iclk;
			half_ff     <= nxt_half;
		end
	end

	// ****************************************************************
	// Pin drivers.
	// ****************************************************************
	assign link.busy         = busy_ff;
	assign link.data_dev     = shifting_ff ? sr_ff[WORD_W-1] : 1'b0;
	assign link.data_oe_n    = cs_n;
	assign link.sbc_dev      = iclk_ff;
	assign link.sbc_dev_oe_n = ext_mode | cs_n;
	assign sample_trigger_n_active_o     = (st_ff != ASR_IDLE);
endmodule : asr_dev

// ===== rtl/asr_host.sv
// Host end: starts conversions and clocks the result out in external mode.
// Assumes the device end and the bench resolve the shared wires.
module asr_host
	import asr_pkg::*;
(
	input  wire logic           clk_i,
	input  wire logic           rst_b_i,
	asr_link_if.host            link,
	input  wire logic           start_i,
	output logic                start_ready_o,
	output logic                word_valid_o,
	input  wire logic           word_ready_i,
	output asr_pkg::asr_word_t  word_o
);
	import asr_pkg::*;

	logic [1:0] b1_ff, b2_ff;
	logic       busy_d_ff, busy_rise;
	asr_host_e              st_ff, nxt_st;
	logic [HALF_CNT_W-1:0]  half_ff, nxt_half;
	logic [CNT_W-1:0]       bit_ff, nxt_bit;
	asr_word_t              sh_ff, nxt_sh;
	logic                   sclk_ff, nxt_sclk;
	logic                   trig_ff, nxt_trig;
	logic                   push, in_ready;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			b1_ff     <= 2'h2;
			b2_ff     <= 2'h2;
			busy_d_ff <= 1'b1;
		end else begin
			b1_ff     <= {link.busy, link.data_line};
			b2_ff     <= b1_ff;
			busy_d_ff <= b2_ff[1];
		end
	end
	assign busy_rise = b2_ff[1] & ~busy_d_ff;

	assign start_ready_o            = (st_ff == ASRH_IDLE);
	assign push                     = (st_ff == ASRH_DONE);
	assign link.clock_source_select = 1'b1;
	assign link.cs_n                = 1'b0;
	assign link.sbc_host            = sclk_ff;
	assign link.sample_trigger_n    = trig_ff;

	always_comb begin
		nxt_st   = st_ff;
		nxt_half = half_ff;
		nxt_bit  = bit_ff;
		nxt_sh   = sh_ff;
		nxt_sclk = sclk_ff;
		nxt_trig = 1'b1;
		case (st_ff)
			ASRH_IDLE: begin
				nxt_sclk = 1'b0;
				if (start_i) begin
					nxt_trig = 1'b0;
				end
				if (busy_rise) begin
					nxt_st   = ASRH_HIGH;
					nxt_bit  = CNT_W'(WORD_W + 1);
					nxt_half = HALF_CNT_W'(HOST_HALF_CYC - 1);
					nxt_sclk = 1'b1;
				end
			end
			ASRH_HIGH: begin
				if (half_ff == '0) begin
					nxt_half = HALF_CNT_W'(HOST_HALF_CYC - 1);
					nxt_sclk = 1'b0;
					nxt_st   = ASRH_LOW;
				end else begin
					nxt_half = half_ff - HALF_CNT_W'(1);
				end
			end
			ASRH_LOW: begin
				if (half_ff == '0) begin
					nxt_sh  = {sh_ff[WORD_W-2:0], b2_ff[0]};
					nxt_bit = bit_ff - CNT_W'(1);
					nxt_half = HALF_CNT_W'(HOST_HALF_CYC - 1);
					if (bit_ff == CNT_W'(2)) begin
						nxt_st = ASRH_DONE;
					end else begin
						nxt_sclk = 1'b1;
						nxt_st   = ASRH_HIGH;
					end
				end else begin
					nxt_half = half_ff - HALF_CNT_W'(1);
				end
			end
			ASRH_DONE: begin
				if (in_ready) begin
					nxt_st = ASRH_IDLE;
				end
			end
			default: begin
				nxt_st = ASRH_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			st_ff   <= ASRH_IDLE;
			half_ff <= '0;
			bit_ff  <= '0;
			sh_ff   <= RESULT_RST;
			sclk_ff <= 1'b0;
			trig_ff <= 1'b1;
		end else begin
			st_ff   <= nxt_st;
			half_ff <= nxt_half;
			bit_ff  <= nxt_bit;
			sh_ff   <= nxt_sh;
			sclk_ff <= nxt_sclk;
			trig_ff <= nxt_trig;
		end
	end

	asr_buf2 u_buf (
		.clk_i       (clk_i),
		.rst_b_i     (rst_b_i),
		.in_valid_i  (push),
		.in_ready_o  (in_ready),
		.in_data_i   (sh_ff),
		.out_valid_o (word_valid_o),
		.out_ready_i (word_ready_i),
		.out_data_o  (word_o)
	);
endmodule : asr_host

// ===== dv/asr_link_properties.sv
// Checker for the link that joins the converter end and the host end.
// Assumes the bench instantiates it beside that link, on the same clock.
module asr_link_properties
	import asr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic sample_trigger_n,
	input wire logic clock_source_select,
	input wire logic cs_n,
	input wire logic busy,
	input wire logic sbc_dev_oe_n,
	input wire logic data_oe_n,
	input wire logic serial_bit_clock
);
	logic [15:0] low_ff;
	logic [15:0] park_ff;
	logic [4:0]  edge_ff;
	logic        sbc_ff;

	// ****************************************************************
	// Helper counters.
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			low_ff  <= 16'h0000;
			park_ff <= 16'h0000;
			edge_ff <= 5'h00;
			sbc_ff  <= 1'b0;
		end else begin
			low_ff  <= busy ? 16'h0000 : low_ff + 16'h0001;
			park_ff <= serial_bit_clock ? 16'h0000 : park_ff + {15'h0000, park_ff != 16'hFFFF};
			edge_ff <= !busy ? 5'h00 : edge_ff + {4'h0, serial_bit_clock & !sbc_ff};
			sbc_ff  <= serial_bit_clock;
		end
	end

	// ****************************************************************
	// Properties.
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	busy_fall_a: assert property ($fell(sample_trigger_n) && busy |-> ##[1:5] !busy)
		else $error("busy did not fall after trigger");
	sample_trigger_n_len_a: assert property ($rose(busy) |-> $past(low_ff) >= SAMPLE_TRIGGER_N_CYCLES && $past(low_ff) <= SAMPLE_TRIGGER_N_CYCLES + 4)
		else $error("busy low time wrong");
	trigger_ignore_a: assert property (!busy && $fell(sample_trigger_n) |=> !busy [*4])
		else $error("trigger disturbed conversion");
	ext_clock_oe_a: assert property (clock_source_select && $past(clock_source_select, 3) |-> sbc_dev_oe_n)
		else $error("bit clock driven in external mode");
	data_enable_a: assert property (!cs_n && !$past(cs_n, 3) && $past(rst_b_i, 3) |-> !data_oe_n)
		else $error("data not enabled while selected");
	park_low_a: assert property ($rose(busy) |-> $past(park_ff) >= PARK_CYCLES)
		else $error("bit clock not parked before busy");
	static_clock_a: assert property (!busy |-> $stable(serial_bit_clock))
		else $error("bit clock moved during conversion");
	edge_count_a: assert property ($fell(busy) |-> $past(edge_ff) == 5'h00 || $past(edge_ff) == 5'h0C)
		else $error("wrong bit clock period count");
endmodule : asr_link_properties

// ===== dv/tb_top.sv
// Bench joining both ends, plus a second converter end driven by the bench.
// Assumes the shared package and link interface are compiled first.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import asr_pkg::*;

	logic      clk_i = 1'b0;
	logic      rst_b_i = 1'b0;
	logic      start_i = 1'b0;
	logic      word_ready_i = 1'b0;
	asr_word_t result_i = 12'h000;
	asr_word_t result2 = 12'h000;
	logic      start_ready;
	logic      word_valid;
	asr_word_t word_o;
	int        errors = 0;
	int        samples_checked = 0;
	int        cycles = 0;

	asr_link_if lk ();
	asr_link_if lk2 ();

	always #2.5 clk_i = ~clk_i;

	assign lk.serial_bit_clock = lk.sbc_dev_oe_n ? lk.sbc_host : lk.sbc_dev;
	assign lk.data_line        = lk.data_oe_n ? ~lk.data_dev : lk.data_dev;

	asr_dev asr_dev_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(lk), .result_i(result_i), .sample_trigger_n_active_o());
	asr_dev asr_dev2_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(lk2), .result_i(result2), .sample_trigger_n_active_o());
	asr_host asr_host_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(lk), .start_i(start_i),
		.start_ready_o(start_ready), .word_valid_o(word_valid), .word_ready_i(word_ready_i), .word_o(word_o));
	asr_link_properties props_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .sample_trigger_n(lk.sample_trigger_n),
		.clock_source_select(lk.clock_source_select), .cs_n(lk.cs_n), .busy(lk.busy),
		.sbc_dev_oe_n(lk.sbc_dev_oe_n), .data_oe_n(lk.data_oe_n), .serial_bit_clock(lk.serial_bit_clock));

	// ****************************************************************
	// Shared tasks.
	// ****************************************************************
	task automatic check(input asr_word_t seen, input asr_word_t exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done

	task automatic host_sample_trigger_n(input asr_word_t v);
		while (!start_ready) @(negedge clk_i);
		start_i = 1'b1;
		@(negedge clk_i);
		start_i = 1'b0;
		while (lk.busy) @(negedge clk_i);
		result_i = v;
		repeat (100) @(negedge clk_i);
		start_i = 1'b1;
		@(negedge clk_i);
		start_i = 1'b0;
		while (!lk.busy) @(negedge clk_i);
		repeat (8) @(negedge clk_i);
		while (!start_ready) @(negedge clk_i);
	endtask : host_sample_trigger_n

	task automatic conv2(input asr_word_t v, input logic hold);
		lk2.sample_trigger_n = 1'b0;
		@(negedge clk_i);
		lk2.sample_trigger_n = 1'b1;
		result2 = v;
		while (lk2.busy) @(negedge clk_i);
		repeat (SAMPLE_TRIGGER_N_CYCLES - 100) @(negedge clk_i);
		lk2.sbc_host = hold;
		while (!lk2.busy) @(negedge clk_i);
		repeat (8) @(negedge clk_i);
		lk2.sbc_host = 1'b0;
		repeat (8) @(negedge clk_i);
	endtask : conv2

	task automatic rd2(input logic started, input asr_word_t exp);
		asr_word_t got;
		for (int i = 11; i >= 0; i--) begin
			if (!(started && i == 11)) begin
				lk2.sbc_host = 1'b1;
				repeat (8) @(negedge clk_i);
				lk2.sbc_host = 1'b0;
				repeat (8) @(negedge clk_i);
			end
			got[i] = lk2.data_dev;
		end
		check(got, exp);
	endtask : rd2

	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	task automatic host_reads();
		asr_word_t vals [3] = '{12'hFFF, 12'h000, 12'hA5A};
		host_sample_trigger_n(12'h7FF);
		host_sample_trigger_n(12'h800);
		while (!start_ready) @(negedge clk_i);
		repeat (3) @(negedge clk_i);
		check(word_o, 12'h7FF);
		word_ready_i = 1'b1;
		@(negedge clk_i);
		check(word_o, 12'h800);
		@(negedge clk_i);
		check(asr_word_t'(word_valid), 12'h000);
		foreach (vals[k]) begin
			host_sample_trigger_n(vals[k]);
			while (!word_valid) @(negedge clk_i);
			check(word_o, vals[k]);
			@(negedge clk_i);
		end
	endtask : host_reads

	task automatic dev2_ops();
		conv2(12'h5A3, 1'b0);
		conv2(12'h1C7, 1'b1);
		rd2(1'b0, 12'h5A3);
		lk2.cs_n = 1'b1;
		conv2(12'h2B8, 1'b1);
		check(asr_word_t'(lk2.data_oe_n), 12'h001);
		lk2.cs_n = 1'b0;
		repeat (4) @(negedge clk_i);
		rd2(1'b0, 12'h2B8);
		lk2.clock_source_select = 1'b0;
		repeat (4) @(negedge clk_i);
		check(asr_word_t'(lk2.sbc_dev_oe_n), 12'h000);
		lk2.cs_n = 1'b1;
		conv2(12'h3E1, 1'b0);
		check(asr_word_t'(lk2.sbc_dev_oe_n), 12'h001);
		check(asr_word_t'(lk2.data_oe_n), 12'h001);
	endtask : dev2_ops

	// ****************************************************************
	// Main sequence and timeout.
	// ****************************************************************
	initial begin
		lk2.sample_trigger_n = 1'b1;
		lk2.clock_source_select = 1'b1;
		lk2.cs_n = 1'b0;
		lk2.sbc_host = 1'b0;
		repeat (6) @(negedge clk_i);
		rst_b_i = 1'b1;
		repeat (4) @(negedge clk_i);
		host_reads();
		dev2_ops();
		test_done();
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			test_done();
		end
	end
endmodule : tb_top
